// ==== fnode_defs.svh ====
// Purpose: constants for the fieldbus node configuration and status block
// Assumes: APB byte addresses, 32-bit data, 50 MHz clock
// Notes: offsets and field positions used by design and bench
`ifndef FNODE_DEFS_SVH
`define FNODE_DEFS_SVH
`define FNODE_CLK_KHZ 50000
`define FNODE_FLASH_HALF_MS 500
`define FNODE_OFS_CTRL 12'h000
`define FNODE_OFS_VARS 12'h004
`define FNODE_OFS_STATUS 12'h008
`define FNODE_OFS_INT_STAT 12'h00C
`define FNODE_OFS_INT_MASK 12'h010
`define FNODE_OFS_SIZES 12'h014
`define FNODE_CTRL_SRC_LSB 0
`define FNODE_CTRL_RUN_BIT 2
`define FNODE_CTRL_RST 3'h0
`define FNODE_VARS_RST 16'h0000
`define FNODE_MASK_RST 5'h00
`define FNODE_CTRL_WORDS 8'h02
`define FNODE_INT_DUP 0
`define FNODE_INT_SIZE 1
`define FNODE_INT_TMO 2
`define FNODE_INT_CRIT 3
`define FNODE_INT_RATE 4
`define FNODE_RATE_RESERVED 2'h3
`endif

// ==== fnode_pkg.sv ====
// Purpose: types for the fieldbus node configuration and status block
// Assumes: nothing beyond the defs header
// Notes: one-hot codes for the indicator patterns
package fnode_pkg;
    typedef enum logic [1:0] {
        RATE_125K = 2'h0,
        RATE_250K = 2'h1,
        RATE_500K = 2'h2,
        RATE_RSVD = 2'h3
    } rate_t;
    typedef enum logic [1:0] {
        SRC_SWITCH = 2'h0,
        SRC_NETWORK = 2'h1,
        SRC_AUTO = 2'h2
    } rate_src_t;
    typedef enum logic [4:0] {
        LED_OFF = 5'h01,
        LED_GREEN = 5'h02,
        LED_RED = 5'h04,
        LED_FLASH_G = 5'h08,
        LED_FLASH_R = 5'h10
    } led_t;
endpackage : fnode_pkg

// ==== fieldbus_node_config_status.sv ====
// Purpose: switch decode, bit-rate choice, I/O image sizing and status indicators
// Assumes: inputs synchronous to i_clk; switches stable while in reset
// Notes: registers over APB; level interrupt from read-clear status
`include "fnode_defs.svh"

// Behaviour
// R1: two-bit switch picks 125k, 250k or 500k; 11 is reserved.
// R2: six-bit switch gives binary node address 0 to 63.
// R3: bit rate comes from switch, network command or autobaud.
// R4: installer sets rate switch before start; sampled once after reset.
// R5: module LED off, red on fatal, green ok, flashing red minor.
// R6: network LED off, green, flashing green, red, flashing red by link state.
// R7: two front LEDs show status; the other two stay off.
// R8: only the polled I/O connection type is accepted.
// R9: master must set I/O byte counts equal to the image sizes.
// R10: master size covers all variables plus status and control words.
// R11: image sizes follow programmed variables plus status and control words. The code caps each size at 254 bytes (8'hFE).
// R12: a frame from another node with our address flags a duplicate.
// R13: DP variant address is tens switch times ten plus units switch.
// R14: on size mismatch the node neither talks nor acknowledges.
// R15: flashing patterns toggle near 1 Hz at 50 percent duty.
module fieldbus_node_config_status
#(
    parameter int FLASH_HALF_CYC = `FNODE_FLASH_HALF_MS * `FNODE_CLK_KHZ
)(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    input wire logic [1:0] i_dip_rate,
    input wire logic [5:0] i_dip_addr,
    input wire logic i_variant_dp,
    input wire logic [3:0] i_rot_tens,
    input wire logic [3:0] i_rot_units,
    input wire logic i_net_rate_wr,
    input wire logic [1:0] i_net_rate,
    input wire logic i_auto_done,
    input wire logic [1:0] i_auto_rate,
    input wire logic i_rx_valid,
    input wire logic [5:0] i_rx_src_addr,
    input wire logic i_conn_polled,
    input wire logic [7:0] i_master_in_bytes,
    input wire logic [7:0] i_master_out_bytes,
    input wire logic i_link_online,
    input wire logic i_link_connected,
    input wire logic i_link_critical,
    input wire logic i_conn_timeout,
    input wire logic i_fault_major,
    input wire logic i_fault_minor,
    output fnode_pkg::rate_t o_bit_rate,
    output logic [6:0] o_node_addr,
    output logic [7:0] o_in_bytes,
    output logic [7:0] o_out_bytes,
    output logic o_io_enable,
    output logic o_mod_led_red,
    output logic o_mod_led_green,
    output logic o_net_led_red,
    output logic o_net_led_green,
    output logic [1:0] o_spare_led,
    output logic o_irq
);
    import fnode_pkg::*;

    // image size in bytes: variables plus status and control words, two bytes each, capped at 8'hFE
    function automatic logic [7:0] image_bytes(input logic [7:0] nvars);
        logic [8:0] words;
        words = {1'b0, nvars} + {1'b0, `FNODE_CTRL_WORDS};
        image_bytes = (words > 9'h07F) ? 8'hFE : {words[6:0], 1'b0};
    endfunction : image_bytes
    function automatic logic [1:0] led_pins(input led_t st, input logic ph);
        case (st)
            LED_GREEN: led_pins = 2'h1;
            LED_RED: led_pins = 2'h2;
            LED_FLASH_G: led_pins = {1'b0, ph};
            LED_FLASH_R: led_pins = {ph, 1'b0};
            default: led_pins = 2'h0;
        endcase
    endfunction : led_pins
    logic [2:0] ctrl_q;
    logic [15:0] vars_q;
    logic [4:0] int_stat_q, int_stat_d;
    logic [4:0] int_mask_q;
    logic sampled_q;
    logic [1:0] sw_rate_q;
    logic [5:0] sw_addr_q;
    logic [6:0] dp_addr_q;
    logic [1:0] net_rate_q;
    logic [1:0] auto_rate_q;
    rate_t rate_q, rate_d;
    logic [31:0] flash_cnt_q;
    logic flash_ph_q;
    logic dup_q;
    logic mismatch_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [7:0] in_bytes_q, out_bytes_q;
    logic io_en_q;
    logic [1:0] mod_led_q, net_led_q;
    logic irq_q;
    logic [6:0] node_addr_q;
    wire logic setup = i_psel & ~i_penable;
    wire logic done = i_psel & i_penable & pready_q;
    wire logic wr_done = done & i_pwrite;
    wire logic rd_done = done & ~i_pwrite;
    wire logic hit_ctrl = (i_paddr == `FNODE_OFS_CTRL);
    wire logic hit_vars = (i_paddr == `FNODE_OFS_VARS);
    wire logic hit_stat = (i_paddr == `FNODE_OFS_STATUS);
    wire logic hit_istat = (i_paddr == `FNODE_OFS_INT_STAT);
    wire logic hit_imask = (i_paddr == `FNODE_OFS_INT_MASK);
    wire logic hit_sizes = (i_paddr == `FNODE_OFS_SIZES);
    wire logic mapped = hit_ctrl | hit_vars | hit_stat | hit_istat | hit_imask | hit_sizes;
    wire rate_src_t src = rate_src_t'(ctrl_q[`FNODE_CTRL_SRC_LSB +: 2]);
    wire logic run = ctrl_q[`FNODE_CTRL_RUN_BIT];
    wire logic [7:0] in_need = image_bytes(vars_q[7:0]); // [R11]
    wire logic [7:0] out_need = image_bytes(vars_q[15:8]); // [R11]
    // master sizes must match the self-sized images exactly [R9] [R10]
    wire logic sizes_ok = (i_master_in_bytes == in_need) && (i_master_out_bytes == out_need);
    wire logic [6:0] own_addr = i_variant_dp ? dp_addr_q : {1'b0, sw_addr_q};
    wire logic dup_hit = i_rx_valid && ({1'b0, i_rx_src_addr} == own_addr); // [R12]
    wire logic [4:0] events;
    led_t mod_st, net_st;
    logic [31:0] rd_mux;
    assign events[`FNODE_INT_DUP] = dup_hit & ~dup_q;
    assign events[`FNODE_INT_SIZE] = ~sizes_ok & ~mismatch_q & run;
    assign events[`FNODE_INT_TMO] = i_conn_timeout;
    assign events[`FNODE_INT_CRIT] = i_link_critical;
    assign events[`FNODE_INT_RATE] = rate_d != rate_q;
    // rate source select; a reserved switch code leaves the rate untouched [R1] [R3]
    always_comb
    begin
        rate_d = rate_q;
        if (src == SRC_NETWORK)
            rate_d = rate_t'(net_rate_q);
        else if (src == SRC_AUTO)
            rate_d = rate_t'(auto_rate_q);
        else if (sw_rate_q != `FNODE_RATE_RESERVED)
            rate_d = rate_t'(sw_rate_q);
    end
    // indicator patterns [R5] [R6]
    always_comb
    begin
        if (i_fault_major)
            mod_st = LED_RED;
        else if (i_fault_minor)
            mod_st = LED_FLASH_R;
        else
            mod_st = LED_GREEN;
        if (i_link_critical || dup_q)
            net_st = LED_RED;
        else if (!i_link_online)
            net_st = LED_OFF;
        else if (i_conn_timeout)
            net_st = LED_FLASH_R;
        else if (i_link_connected && io_en_q)
            net_st = LED_GREEN;
        else
            net_st = LED_FLASH_G;
    end
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
            rd_mux = {29'h0, ctrl_q};
        else if (hit_vars)
            rd_mux = {16'h0, vars_q};
        else if (hit_stat)
            rd_mux = {12'h0, io_en_q, mismatch_q, dup_q, sw_rate_q == `FNODE_RATE_RESERVED,
                      1'b0, own_addr, 4'h0, sw_rate_q, rate_q};
        else if (hit_istat)
            rd_mux = {27'h0, int_stat_q};
        else if (hit_imask)
            rd_mux = {27'h0, int_mask_q};
        else if (hit_sizes)
            rd_mux = {16'h0, out_need, in_need};
    end
    // a read clears only the bits it returned, so an event after setup survives; set wins
    always_comb
    begin
        int_stat_d = int_stat_q;
        if (rd_done && hit_istat)
            int_stat_d = int_stat_q & ~prdata_q[4:0];
        int_stat_d = int_stat_d | events;
    end
    // apb: one wait-free access phase, pready raised from the setup cycle
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q <= (setup && !i_pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            ctrl_q <= `FNODE_CTRL_RST;
            vars_q <= `FNODE_VARS_RST;
            int_mask_q <= `FNODE_MASK_RST;
            int_stat_q <= 5'h00;
        end
        else
        begin
            int_stat_q <= int_stat_d;
            if (wr_done && hit_ctrl)
                ctrl_q <= i_pwdata[2:0];
            if (wr_done && hit_vars)
                vars_q <= i_pwdata[15:0];
            if (wr_done && hit_imask)
                int_mask_q <= i_pwdata[4:0];
        end
    end
    // switches taken once, the first edge after reset release [R4]
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            sampled_q <= 1'b0;
            sw_rate_q <= 2'h0;
            sw_addr_q <= 6'h00;
            dp_addr_q <= 7'h00;
        end
        else if (!sampled_q)
        begin
            sampled_q <= 1'b1;
            sw_rate_q <= i_dip_rate; // [R1]
            sw_addr_q <= i_dip_addr; // [R2]
            dp_addr_q <= 7'(i_rot_tens) * 7'h0A + 7'(i_rot_units); // [R13]
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            net_rate_q <= 2'h0;
            auto_rate_q <= 2'h0;
            rate_q <= RATE_125K;
        end
        else
        begin
            if (i_net_rate_wr && i_net_rate != `FNODE_RATE_RESERVED)
                net_rate_q <= i_net_rate; // [R3]
            if (i_auto_done && i_auto_rate != `FNODE_RATE_RESERVED)
                auto_rate_q <= i_auto_rate; // [R3]
            if (sampled_q)
                rate_q <= rate_d;
        end
    end
    // flash timebase; a long half period is the trade for a wide counter [R15]
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            flash_cnt_q <= 32'h0000_0000;
            flash_ph_q <= 1'b0;
        end
        else if (flash_cnt_q >= 32'(FLASH_HALF_CYC - 1))
        begin
            flash_cnt_q <= 32'h0000_0000;
            flash_ph_q <= ~flash_ph_q; // [R15]
        end
        else
            flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
    end
    // duplicate stays until reset: the node must not claim a taken address [R12]
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            dup_q <= 1'b0;
            mismatch_q <= 1'b0;
            io_en_q <= 1'b0;
        end
        else
        begin
            if (dup_hit)
                dup_q <= 1'b1;
            mismatch_q <= ~sizes_ok & run;
            io_en_q <= run & sizes_ok & i_conn_polled & ~dup_q; // [R8] [R14]
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            in_bytes_q <= 8'h00;
            node_addr_q <= 7'h00;
            out_bytes_q <= 8'h00;
            mod_led_q <= 2'h0;
            net_led_q <= 2'h0;
            irq_q <= 1'b0;
        end
        else
        begin
            in_bytes_q <= in_need; // [R11]
            node_addr_q <= own_addr; // [R2] [R13]
            out_bytes_q <= out_need; // [R11]
            mod_led_q <= led_pins(mod_st, flash_ph_q); // [R5]
            net_led_q <= led_pins(net_st, flash_ph_q); // [R6]
            irq_q <= |(int_stat_d & int_mask_q);
        end
    end
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_prdata = prdata_q;
    assign o_bit_rate = rate_q;
    assign o_node_addr = node_addr_q;
    assign o_in_bytes = in_bytes_q;
    assign o_out_bytes = out_bytes_q;
    assign o_io_enable = io_en_q;
    assign o_mod_led_red = mod_led_q[1];
    assign o_mod_led_green = mod_led_q[0];
    assign o_net_led_red = net_led_q[1];
    assign o_net_led_green = net_led_q[0];
    assign o_spare_led = 2'h0; // [R7]
    assign o_irq = irq_q;
endmodule : fieldbus_node_config_status

// ==== fnode_sva.sv ====
// Purpose: pin-level checks of the node configuration and status block
// Assumes: one clock, synchronous active-low reset
// Notes: checks other than a_rate_legal and a_spare wait until the switches have been sampled after reset
module fnode_sva import fnode_pkg::*;
#(
    parameter int FLASH_HALF_CYC = 4
)(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_variant_dp,
    input wire logic i_rx_valid,
    input wire logic [5:0] i_rx_src_addr,
    input wire logic i_conn_polled,
    input wire logic [7:0] i_master_in_bytes,
    input wire logic i_link_critical,
    input wire logic i_fault_major,
    input wire logic i_fault_minor,
    input wire fnode_pkg::rate_t o_bit_rate,
    input wire logic [6:0] o_node_addr,
    input wire logic [7:0] o_in_bytes,
    input wire logic o_io_enable,
    input wire logic o_mod_led_red,
    input wire logic o_mod_led_green,
    input wire logic o_net_led_red,
    input wire logic o_net_led_green,
    input wire logic [1:0] o_spare_led,
    input wire logic o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] up_q;
    logic live;
    int cnt;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // outputs stay cleared for the first edges after reset
    assign live = (up_q == 2'h3);
    always_ff @(posedge i_clk)
        if (!i_rst_b)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    // length of the current red level while only the minor fault stands
    always_ff @(posedge i_clk)
        if (!i_rst_b || !(i_fault_minor && !i_fault_major) || $changed(o_mod_led_red))
            cnt <= 0;
        else
            cnt <= cnt + 1;
    property p_rate_legal;
        o_bit_rate != RATE_RSVD;
    endproperty
    a_rate_legal: assert property (p_rate_legal) else $error("reserved rate shown");
    property p_polled;
        live && !i_conn_polled |=> !o_io_enable;
    endproperty
    a_polled: assert property (p_polled) else $error("io on without polled");
    property p_size;
        (live && i_master_in_bytes != o_in_bytes) [*2] |=> !o_io_enable;
    endproperty
    a_size: assert property (p_size) else $error("io on with size mismatch");
    property p_dup;
        live && !i_variant_dp && i_rx_valid && i_rx_src_addr == o_node_addr[5:0]
            |-> ##2 (o_net_led_red && !o_io_enable) [*4];
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate address missed");
    property p_mod_red;
        live && i_fault_major |=> o_mod_led_red && !o_mod_led_green;
    endproperty
    a_mod_red: assert property (p_mod_red) else $error("module led not red");
    property p_mod_green;
        live && !i_fault_major && !i_fault_minor |=> o_mod_led_green && !o_mod_led_red;
    endproperty
    a_mod_green: assert property (p_mod_green) else $error("module led not green");
    property p_net_red;
        live && i_link_critical |=> o_net_led_red && !o_net_led_green;
    endproperty
    a_net_red: assert property (p_net_red) else $error("network led not red");
    property p_spare;
        o_spare_led == 2'h0;
    endproperty
    a_spare: assert property (p_spare) else $error("spare led driven");
    property p_flash;
        live && i_fault_minor && !i_fault_major |=> !o_mod_led_green && cnt <= FLASH_HALF_CYC + 1;
    endproperty
    a_flash: assert property (p_flash) else $error("minor fault flash wrong");
    c_io: cover property (o_io_enable);
    c_irq: cover property (o_irq);
    c_flash: cover property (i_fault_minor && o_mod_led_red);
endmodule : fnode_sva

bind fieldbus_node_config_status fnode_sva #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) u_fnode_sva (.*);

// ==== fnode_scanner.sv ====
// Purpose: scanner model that polls the node and sends frames
// Assumes: shares the node clock
// Notes: a wrong size is sent only when the bench commands one
module fnode_scanner (
    input wire logic i_clk,
    input wire logic i_poll,
    input wire logic [7:0] i_cfg_in,
    input wire logic [7:0] i_cfg_out,
    input wire logic i_send,
    input wire logic [5:0] i_src,
    output logic o_conn_polled,
    output logic [7:0] o_in_bytes,
    output logic [7:0] o_out_bytes,
    output logic o_rx_valid,
    output logic [5:0] o_rx_src
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge i_clk)
    begin
        o_conn_polled <= i_poll;
        o_in_bytes <= i_cfg_in;
        o_out_bytes <= i_cfg_out;
        o_rx_valid <= i_send;
        // idle lines show the inverse so a stale address cannot match
        o_rx_src <= i_send ? i_src : ~i_src;
    end
endmodule : fnode_scanner

// ==== fieldbus_node_config_status_tb_top.sv ====
// Purpose: self-checking bench of the node configuration and status block
// Assumes: scanner model on the network side, APB master tasks
// Notes: flash half period shortened to 4 cycles
`include "fnode_defs.svh"
module fieldbus_node_config_status_tb_top import fnode_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [5:0] drv; logic [3:0] exp; logic [3:0] msk;} led_row_t;
    localparam logic [7:0] EIN = 8'(2 * (5 + 2));
    localparam logic [7:0] EOUT = 8'(2 * (3 + 2));
    led_row_t rows [6] = '{'{6'h20, 4'h8, 4'hF}, '{6'h0C, 4'h5, 4'hF}, '{6'h0E, 4'h6, 4'hF},
        '{6'h0D, 4'h4, 4'hD}, '{6'h08, 4'h4, 4'hE}, '{6'h00, 4'h4, 4'hF}};
    logic i_clk = '0, i_rst_b = '0, i_psel = '0, i_penable = '0, i_pwrite = '0;
    logic [11:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, rd, o_prdata;
    logic [1:0] i_dip_rate = 2'h2;
    logic [5:0] i_dip_addr = 6'h03, i_rx_src_addr, src = '0;
    logic [3:0] i_rot_tens = 4'h4, i_rot_units = 4'h2;
    logic [1:0] i_net_rate = 2'h1, i_auto_rate = 2'h0, o_spare_led;
    logic i_variant_dp = '0, i_net_rate_wr = '0, i_auto_done = '0, i_link_online = '0;
    logic i_link_connected = '0, i_link_critical = '0, i_conn_timeout = '0;
    logic i_fault_major = '0, i_fault_minor = '0, poll = '0, send = '0, err;
    logic [7:0] cfg_in = '0, cfg_out = '0, i_master_in_bytes, i_master_out_bytes;
    logic [7:0] o_in_bytes, o_out_bytes;
    logic i_rx_valid, i_conn_polled, o_pready, o_pslverr, o_io_enable, o_irq;
    logic o_mod_led_red, o_mod_led_green, o_net_led_red, o_net_led_green;
    logic [6:0] o_node_addr;
    rate_t o_bit_rate;
    int num_errors = 0;
    int total_checks = 0;
    always #10 i_clk = ~i_clk;
    fieldbus_node_config_status #(.FLASH_HALF_CYC(4)) u_fieldbus_node_config_status (.*);
    fnode_scanner u_fnode_scanner (.i_clk(i_clk), .i_poll(poll), .i_cfg_in(cfg_in),
        .i_cfg_out(cfg_out), .i_send(send), .i_src(src), .o_conn_polled(i_conn_polled),
        .o_in_bytes(i_master_in_bytes), .o_out_bytes(i_master_out_bytes),
        .o_rx_valid(i_rx_valid), .o_rx_src(i_rx_src_addr));
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tend(input string nm);
        $display("test %s finished", nm);
    endtask : tend
    // starts one edge after the last release so psel never gets two values at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_pready !== 1'b1 && n < 20);
        if (o_pready !== 1'b1)
        begin
            num_errors++;
            finish_test();
        end
        else
        begin
            rd = o_prdata;
            err = o_pslverr;
            i_psel <= 1'b0;
            i_penable <= 1'b0;
        end
    endtask : apb
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask : rdchk
    task automatic settle();
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
    endtask : settle
    initial
    begin
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        settle();
        chk("rate", RATE_500K, o_bit_rate);
        chk("addr", 32'h3, o_node_addr);
        rdchk("ctrl", `FNODE_OFS_CTRL, 32'h0);
        rdchk("vars", `FNODE_OFS_VARS, 32'h0);
        rdchk("mask", `FNODE_OFS_INT_MASK, 32'h0);
        rdchk("unmapped", 12'h020, 32'h0);
        chk("slverr", 32'h1, err);
        apb(1'b1, `FNODE_OFS_VARS, 32'h00FF);
        rdchk("sizes_sat", `FNODE_OFS_SIZES, {16'h0, 8'(2 * (0 + 2)), 8'hFE});
        apb(1'b1, `FNODE_OFS_VARS, 32'h0305);
        rdchk("sizes", `FNODE_OFS_SIZES, {16'h0, EOUT, EIN});
        chk("in_bytes", EIN, o_in_bytes);
        chk("out_bytes", EOUT, o_out_bytes);
        cfg_in <= EIN;
        cfg_out <= EOUT;
        poll <= 1'b1;
        apb(1'b1, `FNODE_OFS_CTRL, 32'h1 << `FNODE_CTRL_RUN_BIT);
        settle();
        chk("io_on", 32'h1, o_io_enable);
        tend("config");
        foreach (rows[i])
        begin
            @(posedge i_clk);
            {i_fault_major, i_fault_minor, i_link_online, i_link_connected, i_link_critical,
                i_conn_timeout} <= rows[i].drv;
            settle();
            chk("leds", rows[i].exp & rows[i].msk, {o_mod_led_red, o_mod_led_green,
                o_net_led_red, o_net_led_green} & rows[i].msk);
        end
        @(posedge i_clk);
        i_fault_minor <= 1'b1;
        settle();
        rd[0] = o_mod_led_red;
        repeat (4) @(negedge i_clk);
        chk("flash", 32'h1, 32'(rd[0] ^ o_mod_led_red));
        chk("flash_green", 32'h0, o_mod_led_green);
        @(posedge i_clk);
        i_fault_minor <= 1'b0;
        tend("leds");
        apb(1'b0, `FNODE_OFS_INT_STAT, 32'h0);
        cfg_in <= EIN + 8'h2;
        settle();
        chk("io_mismatch", 32'h0, o_io_enable);
        chk("irq_masked", 32'h0, o_irq);
        apb(1'b1, `FNODE_OFS_INT_MASK, 32'h1 << `FNODE_INT_SIZE);
        settle();
        chk("irq", 32'h1, o_irq);
        rdchk("int_stat", `FNODE_OFS_INT_STAT, 32'h1 << `FNODE_INT_SIZE);
        settle();
        chk("irq_clear", 32'h0, o_irq);
        @(posedge i_clk);
        cfg_in <= EIN;
        poll <= 1'b0;
        settle();
        chk("io_unpolled", 32'h0, o_io_enable);
        @(posedge i_clk);
        poll <= 1'b1;
        settle();
        chk("io_back", 32'h1, o_io_enable);
        tend("sizes");
        for (int s = 1; s < 3; s++)
        begin
            apb(1'b1, `FNODE_OFS_CTRL, 32'h4 | 32'(s));
            i_net_rate_wr <= 1'b1;
            i_auto_done <= 1'b1;
            @(posedge i_clk);
            i_net_rate_wr <= 1'b0;
            i_auto_done <= 1'b0;
            settle();
            chk("rate_src", s == 1 ? RATE_250K : RATE_125K, o_bit_rate);
        end
        tend("rate");
        for (int k = 0; k < 2; k++)
        begin
            @(posedge i_clk);
            src <= k ? 6'h03 : 6'h05;
            send <= 1'b1;
            @(posedge i_clk);
            send <= 1'b0;
            settle();
            chk("io_dup", k ? 32'h0 : 32'h1, o_io_enable);
        end
        chk("led_dup", 32'h1, o_net_led_red);
        chk("spare", 32'h0, o_spare_led);
        tend("duplicate");
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        i_dip_rate <= `FNODE_RATE_RESERVED;
        i_variant_dp <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        settle();
        chk("rate_rsvd", RATE_125K, o_bit_rate);
        chk("addr_dp", 4 * 10 + 2, o_node_addr);
        tend("second reset");
        finish_test();
    end
endmodule : fieldbus_node_config_status_tb_top
